//--- hdl/pfp_port_top.sv
// Port slice top: register file and top-pin multiplexing
//
// Operation
// [RULE1] With its direction bit at one the top pin is an input and the pin-level register bit 7 reads its sampled level.
// [RULE2] With its direction bit at zero the top pin is driven from output latch bit 7.
// [RULE3] The parallel port data bit 0 reaches the top pin only when the remap bit is zero on the large package.
// [RULE4] While the parallel port owns the top pin the direction bit is ignored and the parallel port picks the drive.
// [RULE5] Software sets the top pin's direction bit to one before using the pin as serial slave select input.
// [RULE6] Both analog-select registers appear at their shared addresses only while watchdog control bit 4 is one.
// [RULE7] Unimplemented bits, bit 0 of the port registers and bit 5 of the low analog select, read as zero.
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "pfp_params.svh"
module pfp_port_top
    import pfp_pkg::*;
#(
    parameter int unsigned PORT_W    = 8,
    parameter bit          PKG_LARGE = 1'b1
)
(
    input  wire logic          core_clk_in,
    input  wire logic          rst_in,
    input  wire pfp_bus_req_s  bus_req_in,
    output pfp_byte_t          bus_rdata_out,
    input  wire logic [7:0]    pin_in,
    output logic [7:0]         pin_out,
    output logic [7:0]         pin_oe_n_out,
    input  wire logic          pmp_active_in,
    input  wire logic          pmp_drive_in,
    input  wire logic          pmp_data_out_in,
    output logic               pmp_data_in_out,
    output logic               serial_slave_select_out,
    output pfp_byte_t          analog_select_low_out,
    output pfp_byte_t          analog_select_high_out,
    output logic               pmp_owns_pin_out
);
    if (PORT_W != 8) begin : g_width_check
        $error("pfp_port_top supports an 8-bit port only");
    end

    pfp_byte_t     latch_q;
    pfp_byte_t     latch_d;
    pfp_byte_t     dir_q;
    pfp_byte_t     dir_d;
    pfp_byte_t     wdt_q;
    pfp_byte_t     wdt_d;
    pfp_byte_t     cfg_q;
    pfp_byte_t     cfg_d;
    pfp_byte_t     rdata_q;
    pfp_byte_t     rdata_d;
    pfp_byte_t     sample;
    pfp_byte_t     ovl_rdata;
    logic          ovl_hit;
    logic          map_analog;
    logic          pmp_owns;
    pfp_override_s ovr_seven;

    // Overlay window follows watchdog control bit 4
    assign map_analog = wdt_q[`PFP_WDT_MAP_BIT];  // [RULE6]

    // Parallel port routing onto the top pin
    assign pmp_owns = PKG_LARGE
                    & ~cfg_q[`PFP_CFG_REMAP_BIT]
                    & pmp_active_in;  // [RULE3]

    always_comb begin
        ovr_seven.en    = pmp_owns;
        ovr_seven.drive = pmp_drive_in;    // [RULE4]
        ovr_seven.data  = pmp_data_out_in;
    end

    // Register writes
    always_comb begin
        latch_d = latch_q;
        dir_d   = dir_q;
        wdt_d   = wdt_q;
        cfg_d   = cfg_q;
        if (bus_req_in.wr) begin
            case (bus_req_in.addr)
                `PFP_OFF_PIN_LEVEL: begin
                    latch_d = bus_req_in.wdata & `PFP_PORT_MASK;  // [RULE7]
                end
                `PFP_OFF_OUT_LATCH: begin
                    latch_d = bus_req_in.wdata & `PFP_PORT_MASK;  // [RULE7]
                end
                `PFP_OFF_DIRECTION: begin
                    dir_d = bus_req_in.wdata & `PFP_PORT_MASK;    // [RULE7]
                end
                `PFP_OFF_WDT_CTRL: begin
                    wdt_d = bus_req_in.wdata;
                end
                `PFP_OFF_CONFIG: begin
                    cfg_d = bus_req_in.wdata & `PFP_CFG_MASK;
                end
                default: begin
                    latch_d = latch_q;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            latch_q <= `PFP_RST_LATCH;
            dir_q   <= `PFP_RST_DIRECTION;
            wdt_q   <= `PFP_RST_WDT_CTRL;
            cfg_q   <= `PFP_RST_CONFIG;
        end else begin
            latch_q <= latch_d;
            dir_q   <= dir_d;
            wdt_q   <= wdt_d;
            cfg_q   <= cfg_d;
        end
    end

    // Register reads, data valid the cycle after the strobe
    always_comb begin
        rdata_d = 8'h00;
        if (bus_req_in.rd) begin
            case (bus_req_in.addr)
                `PFP_OFF_PIN_LEVEL: begin
                    rdata_d = sample & `PFP_PORT_MASK;   // [RULE1] [RULE7]
                end
                `PFP_OFF_OUT_LATCH: begin
                    rdata_d = latch_q & `PFP_PORT_MASK;  // [RULE7]
                end
                `PFP_OFF_DIRECTION: begin
                    rdata_d = dir_q & `PFP_PORT_MASK;    // [RULE7]
                end
                `PFP_OFF_WDT_CTRL: begin
                    rdata_d = wdt_q;
                end
                `PFP_OFF_CONFIG: begin
                    rdata_d = cfg_q;
                end
                default: begin
                    rdata_d = ovl_hit ? ovl_rdata : 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    pfp_overlay_regs u_overlay (
        .core_clk_in    (core_clk_in),
        .rst_in         (rst_in),
        .req_in         (bus_req_in),
        .map_analog_in  (map_analog),
        .hit_out        (ovl_hit),
        .rdata_out      (ovl_rdata),
        .ansel_low_out  (analog_select_low_out),
        .ansel_high_out (analog_select_high_out)
    );

    // Pin cells for bits 1 to 7; bit 0 has no pin
    assign sample[0]       = 1'b0;
    assign pin_out[0]      = 1'b0;
    assign pin_oe_n_out[0] = 1'b1;

    for (genvar i = 1; i < 8; i++) begin : g_pin
        pfp_override_s ovr;
        if (i == `PFP_PIN_SEVEN) begin : g_top
            assign ovr = ovr_seven;
        end else begin : g_plain
            assign ovr = '0;
        end
        pfp_pin_cell u_cell (
            .core_clk_in  (core_clk_in),
            .rst_in       (rst_in),
            .pin_in       (pin_in[i]),
            .dir_in       (dir_q[i]),
            .latch_in     (latch_q[i]),
            .ovr_in       (ovr),
            .pin_out      (pin_out[i]),
            .pin_oe_n_out (pin_oe_n_out[i]),
            .sample_out   (sample[i])
        );
    end

    // Sampled top pin feeds the parallel port and the serial slave select
    assign pmp_data_in_out         = sample[`PFP_PIN_SEVEN];
    assign serial_slave_select_out = sample[`PFP_PIN_SEVEN];  // [RULE5]
    assign pmp_owns_pin_out        = pmp_owns;
    assign bus_rdata_out           = rdata_q;
endmodule
`default_nettype wire

//--- hdl/pfp_params.svh
// Register offsets, field positions and reset values of the port slice
`ifndef PFP_PARAMS_SVH
`define PFP_PARAMS_SVH

`define PFP_ADDR_W            8
`define PFP_DATA_W            8

`define PFP_OFF_PIN_LEVEL     8'h00
`define PFP_OFF_OUT_LATCH     8'h01
`define PFP_OFF_DIRECTION     8'h02
`define PFP_OFF_SHARED_LOW    8'h03
`define PFP_OFF_SHARED_HIGH   8'h04
`define PFP_OFF_WDT_CTRL      8'h05
`define PFP_OFF_CONFIG        8'h06

`define PFP_WDT_MAP_BIT       4
`define PFP_CFG_REMAP_BIT     0
`define PFP_PIN_SEVEN         7

`define PFP_PORT_MASK         8'hfe
`define PFP_ANSEL_LOW_MASK    8'hdf
`define PFP_ANSEL_HIGH_MASK   8'hff
`define PFP_CFG_MASK          8'h01

`define PFP_RST_LATCH         8'h00
`define PFP_RST_DIRECTION     8'hfe
`define PFP_RST_ANSEL_LOW     8'h00
`define PFP_RST_ANSEL_HIGH    8'h00
`define PFP_RST_DEFAULT_REG   8'h00
`define PFP_RST_WDT_CTRL      8'h00
`define PFP_RST_CONFIG        8'h01

`endif

//--- hdl/pfp_pkg.sv
// Types shared by the port slice modules
`default_nettype none
package pfp_pkg;

    typedef logic [7:0] pfp_byte_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pfp_bus_req_s;

    typedef struct packed {
        logic       en;
        logic       drive;
        logic       data;
    } pfp_override_s;

endpackage
`default_nettype wire

//--- hdl/pfp_pin_cell.sv
// One port pin: drive selection and input sampling
`timescale 1ns/1ns
`default_nettype none
module pfp_pin_cell
    import pfp_pkg::*;
(
    input  wire logic          core_clk_in,
    input  wire logic          rst_in,
    input  wire logic          pin_in,
    input  wire logic          dir_in,
    input  wire logic          latch_in,
    input  wire pfp_override_s ovr_in,
    output logic               pin_out,
    output logic               pin_oe_n_out,
    output logic               sample_out
);
    logic sample_q;
    logic sample_d;

    always_comb begin
        sample_d = pin_in;
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sample_q <= 1'b0;
        end else begin
            sample_q <= sample_d;
        end
    end

    always_comb begin
        if (ovr_in.en) begin
            pin_out      = ovr_in.data;
            pin_oe_n_out = ~ovr_in.drive;   // [RULE4]
        end else begin
            pin_out      = latch_in;        // [RULE2]
            pin_oe_n_out = dir_in;          // [RULE1]
        end
    end

    assign sample_out = sample_q;
endmodule
`default_nettype wire

//--- hdl/pfp_overlay_regs.sv
// Analog-select registers overlaid on two default registers
`timescale 1ns/1ns
`default_nettype none
`include "pfp_params.svh"
module pfp_overlay_regs
    import pfp_pkg::*;
(
    input  wire logic         core_clk_in,
    input  wire logic         rst_in,
    input  wire pfp_bus_req_s req_in,
    input  wire logic         map_analog_in,
    output logic              hit_out,
    output pfp_byte_t         rdata_out,
    output pfp_byte_t         ansel_low_out,
    output pfp_byte_t         ansel_high_out
);
    pfp_byte_t ansel_low_q;
    pfp_byte_t ansel_low_d;
    pfp_byte_t ansel_high_q;
    pfp_byte_t ansel_high_d;
    pfp_byte_t dflt_low_q;
    pfp_byte_t dflt_low_d;
    pfp_byte_t dflt_high_q;
    pfp_byte_t dflt_high_d;
    logic      sel_low;
    logic      sel_high;

    assign sel_low  = (req_in.addr == `PFP_OFF_SHARED_LOW);
    assign sel_high = (req_in.addr == `PFP_OFF_SHARED_HIGH);
    assign hit_out  = sel_low | sel_high;

    always_comb begin
        ansel_low_d  = ansel_low_q;
        ansel_high_d = ansel_high_q;
        dflt_low_d   = dflt_low_q;
        dflt_high_d  = dflt_high_q;
        if (req_in.wr) begin
            if (map_analog_in) begin                                  // [RULE6]
                if (sel_low) begin
                    ansel_low_d = req_in.wdata & `PFP_ANSEL_LOW_MASK;  // [RULE7]
                end
                if (sel_high) begin
                    ansel_high_d = req_in.wdata & `PFP_ANSEL_HIGH_MASK;
                end
            end else begin
                if (sel_low) begin
                    dflt_low_d = req_in.wdata;
                end
                if (sel_high) begin
                    dflt_high_d = req_in.wdata;
                end
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ansel_low_q  <= `PFP_RST_ANSEL_LOW;
            ansel_high_q <= `PFP_RST_ANSEL_HIGH;
            dflt_low_q   <= `PFP_RST_DEFAULT_REG;
            dflt_high_q  <= `PFP_RST_DEFAULT_REG;
        end else begin
            ansel_low_q  <= ansel_low_d;
            ansel_high_q <= ansel_high_d;
            dflt_low_q   <= dflt_low_d;
            dflt_high_q  <= dflt_high_d;
        end
    end

    always_comb begin
        rdata_out = 8'h00;
        if (sel_low) begin
            rdata_out = map_analog_in ? ansel_low_q : dflt_low_q;    // [RULE6]
        end else if (sel_high) begin
            rdata_out = map_analog_in ? ansel_high_q : dflt_high_q;  // [RULE6]
        end
    end

    assign ansel_low_out  = ansel_low_q;
    assign ansel_high_out = ansel_high_q;
endmodule
`default_nettype wire

//--- sim/pfp_port_top_assertions.sv
// Checker on the port slice top ports
`timescale 1ns/1ns
`default_nettype none
module pfp_port_chk
    import pfp_pkg::*;
#(
    parameter bit PKG_LARGE = 1'b1
)
(
    input wire logic         core_clk_in,
    input wire logic         rst_in,
    input wire pfp_bus_req_s bus_req_in,
    input wire pfp_byte_t    bus_rdata_out,
    input wire logic [7:0]   pin_in,
    input wire logic [7:0]   pin_out,
    input wire logic [7:0]   pin_oe_n_out,
    input wire logic         pmp_active_in,
    input wire logic         pmp_drive_in,
    input wire logic         pmp_data_out_in,
    input wire logic         pmp_owns_pin_out,
    input wire logic         serial_slave_select_out,
    input wire pfp_byte_t    analog_select_low_out
);
    logic [1:0] cfg_q;
    logic [1:0] cfg_d;
    logic       wr3;
    // Tracks analog map bit and remap bit
    always_comb begin
        cfg_d = cfg_q;
        if (bus_req_in.wr && bus_req_in.addr == 8'h05) begin
            cfg_d[1] = bus_req_in.wdata[4];
        end
        if (bus_req_in.wr && bus_req_in.addr == 8'h06) begin
            cfg_d[0] = bus_req_in.wdata[0];
        end
    end
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_q <= 2'h1;
        end else begin
            cfg_q <= cfg_d;
        end
    end
    assign wr3 = bus_req_in.wr && bus_req_in.addr == 8'h03 && cfg_q[1];
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    chk_pin_read: assert property (
        bus_req_in.rd && bus_req_in.addr == 8'h00 && pin_oe_n_out[7] |=> bus_rdata_out[7] == $past(pin_in[7], 2))
        else $error("pin level read wrong");
    chk_pin_sample: assert property (1'b1 |=> serial_slave_select_out == $past(pin_in[7]))
        else $error("pin sample wrong");
    chk_latch_drive: assert property (
        bus_req_in.wr && bus_req_in.addr < 8'h02 && !pin_oe_n_out[7] ##1 !pmp_owns_pin_out && !pin_oe_n_out[7]
        |-> pin_out[7] == $past(bus_req_in.wdata[7]))
        else $error("latch not driven");
    chk_pmp_gate: assert property (pmp_owns_pin_out == (PKG_LARGE && !cfg_q[0] && pmp_active_in))
        else $error("pin ownership wrong");
    chk_pmp_drive: assert property (
        pmp_owns_pin_out |-> pin_oe_n_out[7] == !pmp_drive_in && (!pmp_drive_in || pin_out[7] == pmp_data_out_in))
        else $error("parallel port drive wrong");
    chk_map_gate: assert property ($changed(analog_select_low_out) |-> $past(wr3))
        else $error("analog select changed unmapped");
    chk_low_value: assert property (wr3 |=> analog_select_low_out == ($past(bus_req_in.wdata) & 8'hdf))
        else $error("analog select value wrong");
    chk_bit_zero: assert property (
        bus_req_in.rd && bus_req_in.addr < 8'h03 |=> !bus_rdata_out[0] && pin_oe_n_out[0] && !pin_out[0])
        else $error("bit zero not zero");
    cov_pmp_drive: cover property (pmp_owns_pin_out && pmp_drive_in);
    cov_latch: cover property (!pin_oe_n_out[7] && !pmp_owns_pin_out);
    cov_analog: cover property (wr3);
endmodule
bind pfp_port_top pfp_port_chk #(.PKG_LARGE(PKG_LARGE)) u_chk (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .bus_req_in(bus_req_in), .bus_rdata_out(bus_rdata_out),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n_out(pin_oe_n_out), .pmp_active_in(pmp_active_in),
    .pmp_drive_in(pmp_drive_in), .pmp_data_out_in(pmp_data_out_in), .pmp_owns_pin_out(pmp_owns_pin_out),
    .serial_slave_select_out(serial_slave_select_out), .analog_select_low_out(analog_select_low_out));
`default_nettype wire

//--- sim/pfp_pin_partner.sv
// External circuitry on the port pins
`timescale 1ns/1ns
`default_nettype none
module pfp_pin_partner (
    input  wire logic       core_clk_in,
    input  wire logic [7:0] pin_out_in,
    input  wire logic [7:0] pin_oe_n_in,
    input  wire logic       drive_in,
    input  wire logic [7:0] ext_in,
    output logic      [7:0] pin_in_out
);
    logic [7:0] float_q = 8'h00;
    // Undriven pins wander every cycle
    always @(posedge core_clk_in) begin
        float_q <= ~pin_in_out;
    end
    // Drives only pins the device released
    assign pin_in_out = (~pin_oe_n_in & pin_out_in) | (pin_oe_n_in & (drive_in ? ext_in : float_q));
endmodule
`default_nettype wire

//--- sim/pfp_port_top_bench.sv
// Self-checking bench of the port slice top
`timescale 1ns/1ns
`default_nettype none
module pfp_port_top_bench;
    import pfp_pkg::*;
    logic         core_clk_in = 1'b0;
    logic         rst_in = 1'b1;
    pfp_bus_req_s req = '0;
    pfp_byte_t    rdata, an0_o, an1_o;
    logic [7:0]   pin_in, pin_out, oe_n;
    logic [7:0]   ext = 8'h00;
    logic         act = 1'b0, drv = 1'b0, pdat = 1'b0, drive = 1'b1;
    logic         pmp_in, ss, owns;
    int           fail_count = 0, n_tests = 0;
    int           lat, dir, wdt, cfg, an0, an1, d0, d1, a, d;

    always #2 core_clk_in = ~core_clk_in;

    pfp_port_top #(.PORT_W(8), .PKG_LARGE(1'b1)) DUT (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .bus_req_in(req), .bus_rdata_out(rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n_out(oe_n), .pmp_active_in(act),
        .pmp_drive_in(drv), .pmp_data_out_in(pdat), .pmp_data_in_out(pmp_in),
        .serial_slave_select_out(ss), .analog_select_low_out(an0_o),
        .analog_select_high_out(an1_o), .pmp_owns_pin_out(owns));
    pfp_pin_partner u_far (.core_clk_in(core_clk_in), .pin_out_in(pin_out), .pin_oe_n_in(oe_n),
        .drive_in(drive), .ext_in(ext), .pin_in_out(pin_in));

    function automatic bit own();
        return act && !cfg[0];
    endfunction
    function automatic pfp_byte_t dm();
        pfp_byte_t m;
        m = 8'(~dir) & 8'hfe;
        if (own()) m[7] = drv;
        return m;
    endfunction
    function automatic pfp_byte_t pv();
        pfp_byte_t o;
        o = 8'(lat);
        if (own()) o[7] = pdat;
        return (dm() & o) | (~dm() & ext);
    endfunction
    function automatic pfp_byte_t exp_rd(input int a);
        case (a)
            0: return pv() & 8'hfe;
            3: return 8'(wdt[4] ? an0 : d0);
            4: return 8'(wdt[4] ? an1 : d1);
            1, 2, 5, 6: return 8'(a == 1 ? lat : a == 2 ? dir : a == 5 ? wdt : cfg);
            default: return 8'h00;
        endcase
    endfunction
    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input int a, input int d);
        @(posedge core_clk_in) req <= '{a[7:0], d[7:0], 1'b1, 1'b0};
        @(posedge core_clk_in) req <= '0;
        case (a)
            0, 1: lat = d & 8'hfe;
            2: dir = d & 8'hfe;
            3: if (wdt[4]) an0 = d & 8'hdf; else d0 = d;
            4: if (wdt[4]) an1 = d; else d1 = d;
            5: wdt = d;
            default: cfg = d & 1;
        endcase
    endtask
    task automatic rd(input int a);
        @(posedge core_clk_in) req <= '{a[7:0], 8'h00, 1'b0, 1'b1};
        @(posedge core_clk_in) req <= '0;
        @(negedge core_clk_in);
        if (a != 0 || drive) chk("rdata", rdata, exp_rd(a));
        chk("oe_n", oe_n, ~dm());
        chk("pin_out", pin_out & dm(), pv() & dm());
        chk("owns", {7'h00, owns}, {7'h00, own()});
        chk("an_low", an0_o, 8'(an0));
        chk("an_high", an1_o, 8'(an1));
        if (drive) chk("ss", {7'h00, ss}, pv() >> 7);
        if (drive) chk("pmp_in", {7'h00, pmp_in}, pv() >> 7);
    endtask
    task automatic complete_run();
        if (fail_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        void'($urandom(13356));
        lat = 0;
        dir = 8'hfe;
        wdt = 0;
        cfg = 1;
        {an0, an1, d0, d1} = '0;
        repeat (8) @(posedge core_clk_in);
        rst_in <= 1'b0;
        ext <= 8'($urandom);
        for (int i = 0; i < 9; i++) rd(i);
        rd(8'h80);
        repeat (400) begin
            @(posedge core_clk_in);
            ext <= 8'($urandom);
            act <= 1'($urandom);
            drv <= 1'($urandom);
            pdat <= 1'($urandom);
            drive <= ($urandom_range(3) != 0);
            a = $urandom_range(6);
            d = $urandom_range(255);
            if (a == 5) d = d & 8'h10;
            if (a == 6) d = d & 1;
            wr(a, d);
            rd($urandom_range(8));
        end
        complete_run();
    end
endmodule
`default_nettype wire
